//--- src/rsq_top.sv
`timescale 1ns/100ps
// What this block does
// - Release reset two cycles later, after lock
// - Outputs forced to reset value immediately
// - Handler starts ten cycles after trigger
// - Output valid within ten cycles plus delay
// - Stop exit waits 128K or 25 cycles
// - Pll off in stop, relock on wake
// - Bypassed pll adds no wake wait
// - Accept one request per 12 or 8
// - Dma sustains 6,7,2,3 cycle spacing
module rsq_top #(
  parameter int unsigned STOP_LONG = rsq_pkg::STOP_LONG_CYC,
  parameter int unsigned PLL_LOCK  = rsq_pkg::PLL_LOCK_US * rsq_pkg::CLK_MHZ
) (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        ext_reset_n,
  // Pll
  input  wire logic        pll_locked,
  output logic             pll_power_ff,
  // Interrupt pins
  input  wire logic [3:0]  ext_irq_n,
  input  wire logic        ext_nmi_n,
  // Dma triggers, same clock
  input  wire logic [3:0]  dma_req,
  // Core side
  output logic             core_reset_ff,
  output logic             handler_start_ff,
  output logic [2:0]       handler_src_ff,
  output logic             gpo_ff,
  output logic             dma_grant_ff,
  output logic             stopped_ff,
  // APB
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata_ff,
  output logic             pready,
  output logic             pslverr,
  output logic             irq_ff
);
  localparam int unsigned CW = 18; // Counter width covers 128K

  // ****************************************
  // Synchronisers
  // ****************************************
  logic [5:0] sync_q;
  rsq_sync #(.W(6)) u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .din     ({~ext_nmi_n, ~ext_irq_n, ~ext_reset_n}),
    .dout    (sync_q)
  );
  logic       pin_rst;   // Reset pin asserted
  logic [3:0] irq_lvl;   // Active high lines
  logic       nmi_lvl;
  assign pin_rst = sync_q[0];
  assign irq_lvl = sync_q[4:1];
  assign nmi_lvl = sync_q[5];

  // ****************************************
  // Reset sequencing
  // ****************************************
  logic [1:0]    rel_cnt_ff, nxt_rel_cnt;
  logic          any_rst;
  logic          lock_ok;
  logic [31:0]   ctrl_ff, nxt_ctrl;
  assign any_rst = rst | pin_rst;
  assign lock_ok = ~ctrl_ff[rsq_pkg::CTL_PLL_EN] | pll_locked;

  // Release counter, restarts on each reset assertion
  always_comb begin
    nxt_rel_cnt = rel_cnt_ff;
    if (any_rst) nxt_rel_cnt = '0;
    else if (rel_cnt_ff < 2'(rsq_pkg::SYNC_REL_TC)) nxt_rel_cnt = rel_cnt_ff + 2'd1;
  end
  always_ff @(posedge sys_clk) begin
    rel_cnt_ff <= nxt_rel_cnt;
  end
  // Core reset output, set without waiting on the counter
  always_ff @(posedge sys_clk) begin
    if (any_rst) core_reset_ff <= 1'b1;
    else if (rel_cnt_ff == 2'(rsq_pkg::SYNC_REL_TC) && lock_ok) core_reset_ff <= 1'b0;
  end

  // ****************************************
  // Request detection and rate limit
  // ****************************************
  logic [4:0] lvl_d_ff;       // Previous sampled levels
  logic [4:0] trig;           // Raw triggers
  logic [3:0] gap_ff, nxt_gap;// Acceptance spacing
  logic [4:0] ev_acc;         // Accepted this cycle
  logic       any_trig;
  logic       edge_mode [5];
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_line
      assign edge_mode[gi] = ctrl_ff[rsq_pkg::CTL_EDGE_LO + gi];
      // Edge lines fire on assertion, level lines while held
      assign trig[gi] = edge_mode[gi] ? (irq_lvl[gi] & ~lvl_d_ff[gi]) : irq_lvl[gi];
    end
  endgenerate
  assign edge_mode[4] = 1'b1;
  assign trig[4] = nmi_lvl & ~lvl_d_ff[4];
  assign any_trig = |trig;

  // Chosen spacing for the winning source
  function automatic logic [3:0] rate_of(input logic edge_sel);
    rate_of = edge_sel ? 4'(rsq_pkg::RATE_FAST_CYC) : 4'(rsq_pkg::RATE_SLOW_CYC);
  endfunction

  logic [2:0] win;  // Highest priority source, nmi first
  always_comb begin
    win = 3'd0;
    for (int i = 0; i < 5; i++) if (trig[i]) win = 3'(i);
  end
  // Refuse while gap counter runs
  always_comb begin
    ev_acc  = '0;
    nxt_gap = (gap_ff != 4'h0) ? gap_ff - 4'h1 : 4'h0;
    if (any_trig && gap_ff == 4'h0 && !core_reset_ff) begin
      ev_acc[win] = 1'b1;
      nxt_gap = rate_of(edge_mode[win]) - 4'h1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lvl_d_ff <= '0;
      gap_ff   <= '0;
    end else begin
      lvl_d_ff <= {nmi_lvl, irq_lvl};
      gap_ff   <= nxt_gap;
    end
  end

  // ****************************************
  // Latency pipeline to handler and output
  // ****************************************
  logic [3:0] lat_ff, nxt_lat;  // Cycles since acceptance
  logic       lat_run_ff, nxt_lat_run;
  logic [2:0] src_ff, nxt_src;
  always_comb begin
    nxt_lat = lat_ff;
    nxt_lat_run = lat_run_ff;
    nxt_src = src_ff;
    if (|ev_acc && !lat_run_ff) begin
      nxt_lat = 4'h1;
      nxt_lat_run = 1'b1;
      nxt_src = win;
    end else if (lat_run_ff) begin
      if (lat_ff == 4'(rsq_pkg::IRQ_LAT_TC)) nxt_lat_run = 1'b0;
      else nxt_lat = lat_ff + 4'h1;
    end
  end
  always_ff @(posedge sys_clk) begin
    if (core_reset_ff || rst) begin
      lat_ff <= '0;
      lat_run_ff <= 1'b0;
      src_ff <= '0;
      handler_start_ff <= 1'b0;
      handler_src_ff <= '0;
      gpo_ff <= 1'b0;
    end else begin
      lat_ff <= nxt_lat;
      lat_run_ff <= nxt_lat_run;
      src_ff <= nxt_src;
      // Handler fires in the tenth cycle after trigger
      handler_start_ff <= lat_run_ff && lat_ff == 4'(rsq_pkg::IRQ_LAT_TC - 1);
      if (lat_run_ff && lat_ff == 4'(rsq_pkg::IRQ_LAT_TC - 1)) begin
        handler_src_ff <= src_ff;
        gpo_ff <= ~gpo_ff;
      end
    end
  end

  // ****************************************
  // Dma rate
  // ****************************************
  logic [2:0] dgap_ff, nxt_dgap;
  logic [1:0] dsel;
  function automatic logic [2:0] dma_gap(input logic [1:0] k);
    case (k)
      2'd0:    dma_gap = 3'(rsq_pkg::DMA_RD_CYC);
      2'd1:    dma_gap = 3'(rsq_pkg::DMA_WR_CYC);
      2'd2:    dma_gap = 3'(rsq_pkg::DMA_TMR_CYC);
      default: dma_gap = 3'(rsq_pkg::DMA_EXT_CYC);
    endcase
  endfunction
  always_comb begin
    dsel = 2'd0;
    for (int i = 3; i >= 0; i--) if (dma_req[i]) dsel = 2'(i);
    nxt_dgap = (dgap_ff != 3'h0) ? dgap_ff - 3'h1 : 3'h0;
    if (|dma_req && dgap_ff == 3'h0) nxt_dgap = dma_gap(dsel) - 3'h1;
  end
  always_ff @(posedge sys_clk) begin
    if (rst || core_reset_ff) begin
      dgap_ff <= '0;
      dma_grant_ff <= 1'b0;
    end else begin
      dgap_ff <= nxt_dgap;
      dma_grant_ff <= |dma_req && dgap_ff == 3'h0;
    end
  end

  // ****************************************
  // Stop sequencing
  // ****************************************
  rsq_pkg::rsq_state_e st_ff, nxt_st;
  logic [CW-1:0] wcnt_ff, nxt_wcnt;
  logic [CW-1:0] lcnt_ff, nxt_lcnt;   // Lock wait counter
  logic          stop_req;
  logic          wake_ev;
  logic [CW-1:0] delay_need;
  assign delay_need = ctrl_ff[rsq_pkg::CTL_STOP_FAST] ? CW'(rsq_pkg::STOP_SHORT_CYC) : CW'(STOP_LONG);
  always_comb begin
    nxt_st = st_ff;
    nxt_wcnt = wcnt_ff;
    nxt_lcnt = lcnt_ff;
    wake_ev = 1'b0;
    case (st_ff)
      rsq_pkg::RSQ_RUN: begin
        if (stop_req) nxt_st = rsq_pkg::RSQ_STOP;
      end
      rsq_pkg::RSQ_STOP: begin
        nxt_wcnt = '0;
        nxt_lcnt = '0;
        if (irq_lvl[0]) nxt_st = rsq_pkg::RSQ_WAKE;
      end
      rsq_pkg::RSQ_WAKE: begin
        // Dropped request returns to stop
        if (!irq_lvl[0]) nxt_st = rsq_pkg::RSQ_STOP;
        else begin
          if (wcnt_ff < delay_need) nxt_wcnt = wcnt_ff + 1'b1;
          if (lcnt_ff < CW'(PLL_LOCK)) nxt_lcnt = lcnt_ff + 1'b1;
          // Relock only when pll was enabled and powered down
          if (wcnt_ff >= delay_need && (!ctrl_ff[rsq_pkg::CTL_PLL_EN] || ctrl_ff[rsq_pkg::CTL_PLL_KEEP]
              || (pll_locked && lcnt_ff >= CW'(PLL_LOCK)))) begin
            nxt_st = rsq_pkg::RSQ_RUN;
            wake_ev = 1'b1;
          end
        end
      end
      default: nxt_st = rsq_pkg::RSQ_RUN;
    endcase
  end
  always_ff @(posedge sys_clk) begin
    if (any_rst) begin
      st_ff <= rsq_pkg::RSQ_RUN;
      wcnt_ff <= '0;
      lcnt_ff <= '0;
      stopped_ff <= 1'b0;
      pll_power_ff <= 1'b1;
    end else begin
      st_ff <= nxt_st;
      wcnt_ff <= nxt_wcnt;
      lcnt_ff <= nxt_lcnt;
      stopped_ff <= nxt_st != rsq_pkg::RSQ_RUN;
      // Pll powered down in stop unless kept
      pll_power_ff <= !(nxt_st == rsq_pkg::RSQ_STOP && !ctrl_ff[rsq_pkg::CTL_PLL_KEEP]);
    end
  end

  // ****************************************
  // APB registers and interrupt
  // ****************************************
  logic [6:0]  stat_ff, nxt_stat;
  logic [6:0]  mask_ff, nxt_mask;
  logic [6:0]  ev_set;
  logic        wr, rd;
  logic [31:0] nxt_rdata;
  assign wr = psel & penable & pwrite;
  assign rd = psel & ~penable & ~pwrite;  // Loaded in setup so data stands during access
  assign stop_req = wr && paddr == rsq_pkg::ADDR_CMD && pwdata[0];
  assign pready  = 1'b1;   // Zero wait states
  assign pslverr = 1'b0;
  assign ev_set = {any_trig && gap_ff != 4'h0, wake_ev, ev_acc};
  always_comb begin
    nxt_ctrl = ctrl_ff;
    nxt_mask = mask_ff;
    nxt_stat = stat_ff;
    nxt_rdata = prdata_ff;
    if (wr && paddr == rsq_pkg::ADDR_CTRL) nxt_ctrl = pwdata;
    if (wr && paddr == rsq_pkg::ADDR_MASK) nxt_mask = pwdata[6:0];
    if (wr && paddr == rsq_pkg::ADDR_STATUS) nxt_stat = stat_ff & ~pwdata[6:0];
    nxt_stat = nxt_stat | ev_set;   // Set wins over clear
    if (rd) begin
      case (paddr)
        rsq_pkg::ADDR_CTRL:   nxt_rdata = ctrl_ff;
        rsq_pkg::ADDR_STATUS: nxt_rdata = {25'h0, stat_ff};
        rsq_pkg::ADDR_MASK:   nxt_rdata = {25'h0, mask_ff};
        rsq_pkg::ADDR_STATE:  nxt_rdata = {24'h0, pll_locked, core_reset_ff, lat_run_ff, 3'h0, st_ff};
        default:              nxt_rdata = 32'h0; // Unmapped reads zero
      endcase
    end
  end
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_ff <= rsq_pkg::CTRL_RST;
      mask_ff <= '0;
      stat_ff <= '0;
      prdata_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      ctrl_ff <= nxt_ctrl;
      mask_ff <= nxt_mask;
      stat_ff <= nxt_stat;
      prdata_ff <= nxt_rdata;
      irq_ff <= |(nxt_stat & nxt_mask);
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence s_accept;
    |ev_acc;
  endsequence
  chk_irq_latency: assert property (@(posedge sys_clk) disable iff (rst || core_reset_ff)
    (s_accept and !lat_run_ff) |-> ##10 handler_start_ff)
    else $error("handler start not ten cycles after accept");
  chk_gpo_valid: assert property (@(posedge sys_clk) disable iff (rst || core_reset_ff)
    handler_start_ff |-> gpo_ff != $past(gpo_ff))
    else $error("output did not change with handler start");
  chk_rate_space: assert property (@(posedge sys_clk) disable iff (rst || core_reset_ff)
    s_accept |=> !(|ev_acc) [*7])
    else $error("second request inside eight cycles");
  chk_dma_space: assert property (@(posedge sys_clk) disable iff (rst || core_reset_ff)
    dma_grant_ff |=> !dma_grant_ff)
    else $error("dma grants back to back");
  chk_reset_force: assert property (@(posedge sys_clk)
    any_rst |=> core_reset_ff)
    else $error("core reset not forced");
  chk_reset_hold: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(core_reset_ff) |-> !any_rst && $past(!any_rst, 2))
    else $error("reset released too early");
  chk_stop_short: assert property (@(posedge sys_clk) disable iff (any_rst)
    st_ff == rsq_pkg::RSQ_WAKE && ctrl_ff[rsq_pkg::CTL_STOP_FAST] && wcnt_ff < 18'd25 |=> st_ff != rsq_pkg::RSQ_RUN)
    else $error("stop exit before delay");
  chk_pll_down: assert property (@(posedge sys_clk) disable iff (any_rst)
    st_ff == rsq_pkg::RSQ_STOP && $stable(st_ff) && !ctrl_ff[rsq_pkg::CTL_PLL_KEEP] |-> !pll_power_ff)
    else $error("pll powered in stop");
  chk_sync_path: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(irq_lvl[0]) |-> $past(u_sync.s3_ff[1]))
    else $error("line changed without synchroniser");
endmodule : rsq_top

//--- src/rsq_pkg.sv
package rsq_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int unsigned CLK_MHZ          = 50;   // Core clock rate
  localparam int unsigned RST_MIN_TC       = 2;    // Reset width, core periods
  localparam int unsigned SYNC_REL_TC      = 2;    // Reset release delay, core periods
  localparam int unsigned IRQ_LAT_TC       = 10;   // Trigger to handler start
  localparam int unsigned GPO_EXTRA_NS     = 3;    // Fixed output delay past latency
  localparam int unsigned GPO_EXTRA_CYC    = (GPO_EXTRA_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned STOP_LONG_CYC    = 131072; // 128K core cycles
  localparam int unsigned STOP_SHORT_CYC   = 25;   // Short stop exit
  localparam int unsigned RATE_SLOW_CYC    = 12;   // Peripheral and level lines
  localparam int unsigned RATE_FAST_CYC    = 8;    // Edge and nmi lines
  localparam int unsigned DMA_RD_CYC       = 6;    // Peripheral read
  localparam int unsigned DMA_WR_CYC       = 7;    // Peripheral write
  localparam int unsigned DMA_TMR_CYC      = 2;    // Timer trigger
  localparam int unsigned DMA_EXT_CYC      = 3;    // External trigger
  localparam int unsigned PLL_LOCK_US      = 500;  // Lock wait default

  // ****************************************
  // Register map (APB byte addresses)
  // ****************************************
  localparam logic [7:0] ADDR_CTRL   = 8'h00;  // Mode and pll control bits
  localparam logic [7:0] ADDR_STATUS = 8'h04;  // Sticky events, write one clears
  localparam logic [7:0] ADDR_MASK   = 8'h08;  // Interrupt mask
  localparam logic [7:0] ADDR_STATE  = 8'h0C;  // Live state
  localparam logic [7:0] ADDR_CMD    = 8'h10;  // Stop request, bit zero of the write data

  // Control field positions
  localparam int unsigned CTL_STOP_FAST = 6;   // Stop-delay mode bit
  localparam int unsigned CTL_PLL_KEEP  = 12;  // Keep pll running in stop
  localparam int unsigned CTL_PLL_EN    = 13;  // Pll enabled
  localparam int unsigned CTL_EDGE_LO   = 16;  // Edge mode per line, four bits
  localparam logic [31:0] CTRL_RST      = 32'h0000_0000;

  // Status bits
  localparam int unsigned ST_IRQ_LO   = 0;     // Four line events
  localparam int unsigned ST_NMI      = 4;
  localparam int unsigned ST_WAKE     = 5;
  localparam int unsigned ST_DROP     = 6;     // Request refused by rate limit
  localparam int unsigned ST_W        = 7;

  typedef enum logic [1:0] {RSQ_RUN, RSQ_STOP, RSQ_WAKE} rsq_state_e;

endpackage : rsq_pkg

//--- src/rsq_sync.sv
`timescale 1ns/100ps
// Three-stage input synchroniser, change counts when stages two and three agree
module rsq_sync #(
  parameter int unsigned W = 1
) (
  // Clock
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // Data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] s1_ff, s2_ff, s3_ff; // Stages
  logic [W-1:0] q_ff;                // Filtered value

  // ****************************************
  // Stages
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      q_ff  <= '0;
    end else begin
      s1_ff <= din;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      // Only agreed bits move, glitch on one stage is ignored
      q_ff  <= (s2_ff & s3_ff) | (q_ff & (s2_ff | s3_ff));
    end
  end
  assign dout = q_ff;
endmodule : rsq_sync

//--- dv/rsq_ext_model.sv
`timescale 1ns/100ps
// ****************************************
// Pin-side system model
// ****************************************
module rsq_ext_model #(
  parameter int unsigned LOCK_DLY = 6  // Cycles from power on to lock
) (
  // Clock
  input  wire logic       sys_clk,
  // Pll
  input  wire logic       pll_power_ff,
  output logic            pll_locked,
  // Pins
  output logic            ext_reset_n,
  output logic [3:0]      ext_irq_n,
  output logic            ext_nmi_n
);
  int unsigned lock_cnt = 0;  // Cycles since pll powered

  // Idle pins at time zero
  initial begin
    pll_locked  = 1'b0;
    ext_reset_n = 1'b1;
    ext_irq_n   = 4'hF;
    ext_nmi_n   = 1'b1;
  end

  // Lock lags power, drops at once when power goes away
  always @(posedge sys_clk) begin
    lock_cnt   <= pll_power_ff ? lock_cnt + 1 : 0;
    pll_locked <= pll_power_ff && (lock_cnt >= LOCK_DLY);
  end

  // Drive one request line, index four is the nmi pin
  task automatic set_line(input int unsigned idx, input logic v);
    if (idx == 4) begin
      ext_nmi_n <= v;
    end else begin
      ext_irq_n[idx[1:0]] <= v;
    end
  endtask : set_line

  // Reset pin low, clamped so it is never shorter than legal
  task automatic reset_pulse(input int unsigned cyc);
    ext_reset_n <= 1'b0;
    repeat (cyc < 2 ? 2 : cyc) @(posedge sys_clk);
    ext_reset_n <= 1'b1;
  endtask : reset_pulse

  // Edge request: low then high, both at least two cycles
  task automatic irq_pulse(input int unsigned idx, input int unsigned lo, input int unsigned hi);
    set_line(idx, 1'b0);
    repeat (lo < 2 ? 2 : lo) @(posedge sys_clk);
    set_line(idx, 1'b1);
    repeat (hi < 2 ? 2 : hi) @(posedge sys_clk);
  endtask : irq_pulse
endmodule : rsq_ext_model

//--- dv/tb_reset_stop_irq_sequencer.sv
`timescale 1ns/100ps
// ****************************************
// Bench for the reset, stop and irq sequencer
// ****************************************
module tb_reset_stop_irq_sequencer;
  localparam int unsigned SL = 40;  // Short stop count keeps the run brief
  localparam int unsigned PL = 30;  // Short lock count
  logic        sys_clk = 1'b0;      // Core clock
  logic        rst     = 1'b1;      // Sync reset
  logic        pll_locked, pll_power_ff, ext_reset_n, ext_nmi_n;
  logic [3:0]  ext_irq_n;           // Request pins
  logic [3:0]  dma_req = 4'h0;      // Dma triggers
  logic        core_reset_ff, handler_start_ff, gpo_ff, dma_grant_ff, stopped_ff;
  logic [2:0]  handler_src_ff;      // Handler source
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;       // APB address
  logic [31:0] pwdata = 32'h0, prdata_ff, q;
  logic        pready, pslverr, irq_ff, g0;
  int unsigned err_total = 0;       // Mismatches
  int unsigned n_checks  = 0;       // Comparisons
  int unsigned n, idx, exp_st;      // Scratch
  int unsigned dma_gap [4] = '{6, 7, 2, 3};

  always #10 sys_clk = ~sys_clk;

  rsq_top #(.STOP_LONG(SL), .PLL_LOCK(PL)) uut (.sys_clk(sys_clk), .rst(rst), .ext_reset_n(ext_reset_n),
    .pll_locked(pll_locked), .pll_power_ff(pll_power_ff), .ext_irq_n(ext_irq_n), .ext_nmi_n(ext_nmi_n),
    .dma_req(dma_req), .core_reset_ff(core_reset_ff), .handler_start_ff(handler_start_ff),
    .handler_src_ff(handler_src_ff), .gpo_ff(gpo_ff), .dma_grant_ff(dma_grant_ff), .stopped_ff(stopped_ff),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata_ff(prdata_ff), .pready(pready), .pslverr(pslverr), .irq_ff(irq_ff));

  rsq_ext_model model (.sys_clk(sys_clk), .pll_power_ff(pll_power_ff), .pll_locked(pll_locked),
    .ext_reset_n(ext_reset_n), .ext_irq_n(ext_irq_n), .ext_nmi_n(ext_nmi_n));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic tick(input int unsigned c);
    repeat (c) @(posedge sys_clk);
  endtask : tick

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  // One APB transfer; read data taken at the access edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    penable <= 1'b0;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    r = prdata_ff;
    chk("pslverr", 0, pslverr);
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask : apb

  // Enter stop, wake on held line 0, time the exit
  task automatic stop_run(input logic [31:0] ctl, input int unsigned lo, input int unsigned hi);
    apb(1'b1, rsq_pkg::ADDR_CTRL, ctl, q);
    apb(1'b1, rsq_pkg::ADDR_CMD, 32'h1, q);
    tick(3);
    chk("stopped", 1, stopped_ff);
    if (ctl[13]) chk("pll_power", {31'h0, ctl[12]}, pll_power_ff);
    model.set_line(0, 1'b0);
    n = 0;
    while (stopped_ff !== 1'b0 && n < 300) begin
      @(posedge sys_clk);
      n++;
    end
    chk("wake_min", 1, n >= lo);
    chk("wake_max", 1, n <= hi);
    model.set_line(0, 1'b1);
    tick(20);
  endtask : stop_run

  task automatic complete_run();
    if (err_total == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  // Watchdog: far beyond the expected run length
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    complete_run();
  end

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    void'($urandom(68));
    tick(16);
    chk("rst_core", 1, core_reset_ff);
    chk("rst_pll", 1, pll_power_ff);
    chk("rst_irq", 0, irq_ff);
    rst <= 1'b0;
    tick(20);
    // Pin reset: seen inside, released no sooner than two cycles
    model.reset_pulse(2);
    n = 0;
    g0 = 1'b0;
    while ((core_reset_ff !== 1'b0 || !g0) && n < 40) begin
      @(posedge sys_clk);
      if (core_reset_ff === 1'b1) g0 = 1'b1;
      n++;
    end
    chk("pin_rst_seen", 1, g0);
    chk("rel_min", 1, n >= 3 + rsq_pkg::SYNC_REL_TC);
    chk("rel_max", 1, n <= 20);
    apb(1'b0, 8'h40, 32'h0, q);
    chk("unmapped", 0, q);
    // Each dma class at its own spacing
    for (int k = 0; k < 4; k++) begin
      dma_req <= 4'h1 << k;
      n = 0;
      while (dma_grant_ff !== 1'b1 && n < 30) begin
        @(posedge sys_clk);
        n++;
      end
      n = 0;
      do begin
        @(posedge sys_clk);
        n++;
      end while (dma_grant_ff !== 1'b1 && n < 30);
      chk("dma_gap", dma_gap[k], n);
      dma_req <= 4'h0;
      tick(12);
    end
    stop_run(32'h0000_0040, 25, 33);
    stop_run(32'h0000_0000, SL, SL + 8);
    stop_run(32'h0000_2040, PL, 25 + PL + 20);
    stop_run(32'h0000_3040, 25, 33);
    // Random edge requests, each timed to its handler
    apb(1'b1, rsq_pkg::ADDR_CTRL, 32'h000F_0000, q);
    apb(1'b1, rsq_pkg::ADDR_STATUS, 32'h7F, q);
    apb(1'b1, rsq_pkg::ADDR_MASK, 32'h1F, q);
    exp_st = 0;
    repeat (8) begin
      idx = $urandom_range(0, 4);
      g0 = gpo_ff;
      n = 0;
      fork
        model.irq_pulse(idx, $urandom_range(2, 5), 2);
        while (handler_start_ff !== 1'b1 && n < 60) begin
          @(posedge sys_clk);
          n++;
        end
      join
      chk("lat_min", 1, n >= rsq_pkg::IRQ_LAT_TC);
      chk("lat_max", 1, n <= rsq_pkg::IRQ_LAT_TC + rsq_pkg::GPO_EXTRA_CYC + 6);
      chk("src", idx, handler_src_ff);
      tick(1);
      chk("gpo", {31'h0, ~g0}, gpo_ff);
      exp_st |= 1 << idx;
      chk("irq_on", 1, irq_ff);
      tick($urandom_range(14, 30));
    end
    apb(1'b0, rsq_pkg::ADDR_STATUS, 32'h0, q);
    chk("status", exp_st, q & 32'h7F);
    apb(1'b1, rsq_pkg::ADDR_STATUS, 32'h7F, q);
    tick(3);
    chk("irq_off", 0, irq_ff);
    // Requests closer than eight cycles: the second is refused
    apb(1'b1, rsq_pkg::ADDR_MASK, 32'h40, q);
    model.irq_pulse(4, 2, 2);
    model.irq_pulse(4, 2, 2);
    tick(30);
    apb(1'b0, rsq_pkg::ADDR_STATUS, 32'h0, q);
    chk("dropped", 1, q[6]);
    chk("irq_drop", 1, irq_ff);
    complete_run();
  end
endmodule : tb_reset_stop_irq_sequencer
